// *** core/iors_io_core.sv ***
/*
  Discrete I/O image handling with immediate refresh and matrix scan.
  Assumes the program sequencer issues scan_start, end_done and refresh
  requests as one-cycle pulses on this clock; field inputs are asynchronous.
*/
// Function
// - Sample inputs to image before step zero.
// - Outputs latch from image after end or on output refresh.
// - Immediate refresh updates points mid scan.
// - Input refresh covers points zero to seventeen octal.
// - Output refresh covers points zero to seven.
// - Refresh count 8 or 16, else error.
// - Refresh also works during interrupt processing.
// - Eight columns, two to eight rows.
// - Rows cycle; each row stores own result byte.
// - Rows advance every 20 ms immediately.
`timescale 1ns/10ps
`default_nettype none

module iors_io_core
   import iors_pkg::*;
#(
   parameter int IN_POINTS  = IORS_IN_POINTS,
   parameter int OUT_POINTS = IORS_OUT_POINTS,
   parameter int ROW_CYCLES = IORS_ROW_CYCLES
)
(
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [IN_POINTS-1:0]  in_pins,
   output logic      [OUT_POINTS-1:0] out_pins,
   input  wire logic                  scan_start,
   input  wire logic                  end_done,
   output logic      [IN_POINTS-1:0]  in_image,
   input  wire logic                  img_we,
   input  wire logic [3:0]            img_index,
   input  wire logic                  img_value,
   output logic      [OUT_POINTS-1:0] out_image,
   input  wire logic                  ref_req,
   input  wire logic                  ref_is_out,
   input  wire logic [4:0]            ref_start,
   input  wire logic [4:0]            ref_count,
   output logic                       ref_error,
   input  wire logic                  matrix_scan_op,
   input  wire logic [3:0]            mtx_rows,
   input  wire logic [1:0]            mtx_col_group,
   output logic      [IORS_ROWS_MAX-1:0] mtx_row_out,
   output logic      [IORS_ROWS_MAX*IORS_GROUP-1:0] mtx_result,
   output logic                       mtx_error
);

   // ========================================================================
   // Input synchroniser
   logic [IN_POINTS-1:0] pin_meta;
   logic [IN_POINTS-1:0] pin_sync;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= in_pins;
         pin_sync <= pin_meta;
      end
   end

   // ========================================================================
   // Request checks
   logic ref_ok;
   logic ref_range_ok;
   logic mtx_ok;

   always_comb
   begin
      ref_ok = (ref_count == IORS_COUNT_8) || (ref_count == IORS_COUNT_16);
      // Misaligned starts are the requester's fault; they are refused too.
      if (ref_start[2:0] != 3'h0)
         ref_ok = 1'b0;
      if (ref_is_out)
         ref_range_ok = (ref_start == 5'h00);
      else
         ref_range_ok = ({1'b0, ref_start} + {1'b0, ref_count})
                        <= 6'(IORS_REF_IN_MAX);
      mtx_ok = (mtx_rows >= 4'(IORS_ROWS_MIN))
               && (mtx_rows <= 4'(IORS_ROWS_MAX))
               && (mtx_col_group
                   >= 2'(IORS_MTX_COL_BASE / IORS_GROUP));
   end

   // ========================================================================
   // Row sequencer
   iors_row_if row_bus ();

   assign row_bus.enable = matrix_scan_op && mtx_ok;
   assign row_bus.rows   = mtx_rows;

   iors_row_seq #(
      .ROW_CYCLES (ROW_CYCLES)
   ) u_row_seq (
      .clock (clock),
      .rst_n (rst_n),
      .bus   (row_bus)
   );

   // ========================================================================
   // Images, latch and matrix state
   logic [IN_POINTS-1:0]  next_in_image;
   logic [OUT_POINTS-1:0] next_out_image;
   logic [OUT_POINTS-1:0] next_out_pins;
   logic                  next_ref_error;
   logic                  next_mtx_error;
   logic [IORS_ROWS_MAX-1:0] next_mtx_row_out;
   logic [IORS_ROWS_MAX*IORS_GROUP-1:0] next_mtx_result;
   logic [IORS_GROUP-1:0] columns;

   // Columns are an aligned byte of the synchronised inputs; only groups from point 16 up pass mtx_ok.
   assign columns = pin_sync[{mtx_col_group, 3'h0} +: IORS_GROUP];

   always_comb
   begin
      next_in_image    = in_image;
      next_out_image   = out_image;
      next_out_pins    = out_pins;
      next_ref_error   = 1'b0;

      if (img_we)
         next_out_image[img_index] = img_value;

      if (scan_start)
         next_in_image = pin_sync;

      if (end_done)
         next_out_pins = next_out_image;

      // Refresh works on any cycle, including interrupt service.
      if (ref_req)
      begin
         if (ref_ok && ref_range_ok)
         begin
            if (ref_is_out)
               next_out_pins[ref_start[3:0] +: IORS_REF_OUT_MAX] =
                  next_out_image[ref_start[3:0] +: IORS_REF_OUT_MAX];
            else if (ref_count == IORS_COUNT_16)
               next_in_image[IORS_REF_IN_MAX-1:0] =
                  pin_sync[IORS_REF_IN_MAX-1:0];
            else
               next_in_image[ref_start[3:0] +: IORS_GROUP] =
                  pin_sync[ref_start[3:0] +: IORS_GROUP];
         end
         else
         begin
            next_ref_error = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_image    <= '0;
         out_image   <= '0;
         out_pins    <= '0;
         ref_error   <= 1'b0;
      end
      else
      begin
         in_image    <= next_in_image;
         out_image   <= next_out_image;
         out_pins    <= next_out_pins;
         ref_error   <= next_ref_error;
      end
   end

   // ========================================================================
   // Matrix rows and results
   // The row interval must be at least four cycles: a shorter one would
   // capture the columns before the synchroniser has seen the new row.
   always_comb
   begin
      next_mtx_error   = matrix_scan_op && !mtx_ok;
      next_mtx_row_out = '0;
      next_mtx_result  = mtx_result;

      if (row_bus.row_valid)
      begin
         next_mtx_row_out[row_bus.row] = 1'b1;
         // Columns are captured in the last cycle of each row interval so
         // the field wiring has settled; result row 0 sits in the low byte.
         if (row_bus.tick)
            next_mtx_result[row_bus.row*IORS_GROUP +: IORS_GROUP] =
               columns;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mtx_error   <= 1'b0;
         mtx_row_out <= '0;
         mtx_result  <= '0;
      end
      else
      begin
         mtx_error   <= next_mtx_error;
         mtx_row_out <= next_mtx_row_out;
         mtx_result  <= next_mtx_result;
      end
   end

endmodule

`default_nettype wire

// *** inc/iors_pkg.sv ***
/*
  Shared constants and types for the discrete I/O refresh and matrix scan
  block. Assumes a 20 MHz system clock.
*/
`default_nettype none

package iors_pkg;

   // =========================================================================
   // Point counts and widths
   localparam int  IORS_IN_POINTS   = 32;
   localparam int  IORS_OUT_POINTS  = 16;
   localparam int  IORS_REF_IN_MAX  = 16;
   localparam int  IORS_REF_OUT_MAX = 8;
   localparam int  IORS_GROUP       = 8;
   localparam int  IORS_MTX_COL_BASE = 16;
   localparam int  IORS_ROWS_MAX    = 8;
   localparam int  IORS_ROWS_MIN    = 2;
   localparam logic [4:0] IORS_COUNT_8  = 5'h08;
   localparam logic [4:0] IORS_COUNT_16 = 5'h10;

   // =========================================================================
   // Timing
   localparam int  IORS_CLOCK_HZ    = 20000000;
   localparam int  IORS_ROW_MS      = 20;
   localparam int  IORS_ROW_CYCLES  = IORS_CLOCK_HZ / 1000 * IORS_ROW_MS;

   // =========================================================================
   // Scan phases
   typedef enum logic [1:0] {
      IORS_IDLE,
      IORS_SAMPLE,
      IORS_RUN,
      IORS_END
   } iors_phase_type;

endpackage

`default_nettype wire

// *** inc/iors_row_if.sv ***
/*
  Carrier between the scan controller and the matrix row sequencer.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface iors_row_if;
   import iors_pkg::*;

   logic       enable;
   logic [3:0] rows;
   logic       tick;
   logic [2:0] row;
   logic       row_valid;

   modport ctrl
   (
      output enable,
      output rows,
      input  tick,
      input  row,
      input  row_valid
   );

   modport seq
   (
      input  enable,
      input  rows,
      output tick,
      output row,
      output row_valid
   );
endinterface

`default_nettype wire

// *** core/iors_row_seq.sv ***
/*
  Row sequencer of the matrix scan: steps through rows on a fixed interval.
  Assumes the controller holds enable and a valid row count while active.
*/
`timescale 1ns/10ps
`default_nettype none

module iors_row_seq
   import iors_pkg::*;
#(
   parameter int ROW_CYCLES = IORS_ROW_CYCLES
)
(
   input  wire logic clock,
   input  wire logic rst_n,
   iors_row_if.seq   bus
);

   logic [31:0] timer;
   logic [31:0] next_timer;
   logic [2:0]  row;
   logic [2:0]  next_row;
   logic        next_tick;

   always_comb
   begin
      next_timer = timer;
      next_row   = row;
      next_tick  = 1'b0;
      if (!bus.enable)
      begin
         next_timer = 32'h0;
         next_row   = 3'h0;
      end
      else if (timer >= 32'(ROW_CYCLES - 1))
      begin
         // Row advances every interval and wraps after the last row.
         next_timer = 32'h0;
         next_tick  = 1'b1;
         if ({1'b0, row} >= bus.rows - 4'h1)
            next_row = 3'h0;
         else
            next_row = row + 3'h1;
      end
      else
      begin
         next_timer = timer + 32'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer <= 32'h0;
         row   <= 3'h0;
      end
      else
      begin
         timer <= next_timer;
         row   <= next_row;
      end
   end

   // The tick marks the last cycle of a row while that row is still current,
   // so the capture lands in the row's own result byte.
   assign bus.tick      = next_tick;
   assign bus.row       = row;
   assign bus.row_valid = bus.enable;

endmodule

`default_nettype wire

// *** test/iors_keys.sv ***
/*
  Switch matrix model: drives a column byte for the one row that is on.
  Assumes one-hot row drive from the core; no pull on the column lines.
*/
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Key matrix
module iors_keys
(
   input  wire logic [7:0] rows,
   output var  logic [7:0] cols
);
   logic [7:0] key;
   logic [7:0] last = 8'h5A;
   always_comb
   begin
      key = 8'h00;
      for (int r = 0; r < 8; r++)
         if (rows[r]) key = 8'(8'h11 * (r + 1));
   end
   always @(key) if (key != 8'h00) last = key;
   // Undriven columns float, so they show the inverse of the last byte.
   assign cols = (rows == 8'h00) ? ~last : key;
endmodule
`default_nettype wire

// *** test/iors_io_core_properties.sv ***
/*
  Port checker of the I/O core.
  Assumes it is bound to every instance of iors_io_core.
*/
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Checker
module iors_io_core_properties
   import iors_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        scan_start,
   input wire logic        end_done,
   input wire logic [31:0] in_image,
   input wire logic [15:0] out_pins,
   input wire logic        ref_req,
   input wire logic        ref_is_out,
   input wire logic [4:0]  ref_start,
   input wire logic [4:0]  ref_count,
   input wire logic        ref_error,
   input wire logic        matrix_scan_op,
   input wire logic [3:0]  mtx_rows,
   input wire logic [7:0]  mtx_row_out,
   input wire logic [63:0] mtx_result,
   input wire logic        mtx_error
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_image_cause: assert property ($changed(in_image) |->
      $past(scan_start || ref_req)) else $error("input image moved");
   chk_pin_cause: assert property ($changed(out_pins) |->
      $past(end_done || (ref_req && ref_is_out))) else $error("pins moved");
   chk_bad_count: assert property (ref_req && ref_count != IORS_COUNT_8 &&
      ref_count != IORS_COUNT_16 |=> ref_error)
      else $error("bad count accepted");
   chk_out_high_held: assert property (ref_req && ref_is_out &&
      !end_done |=> $stable(out_pins[15:8])) else $error("high pins moved");
   chk_in_byte_only: assert property (ref_req && !ref_is_out &&
      ref_start == 5'h08 && ref_count == IORS_COUNT_8 && !scan_start |=>
      $stable(in_image[7:0]) && $stable(in_image[31:16]))
      else $error("refresh touched other points");
   chk_rows_onehot: assert property ($onehot0(mtx_row_out))
      else $error("more than one row on");
   chk_idle_rows: assert property (!matrix_scan_op ##1
      !matrix_scan_op |-> mtx_row_out == 8'h00 && $stable(mtx_result))
      else $error("idle scan active");
   chk_bad_rows: assert property (matrix_scan_op &&
      (mtx_rows < 4'h2 || mtx_rows > 4'h8) |=> mtx_error)
      else $error("bad row count accepted");
   cover property (ref_error);
   cover property (end_done ##1 $changed(out_pins));
   cover property ($rose(mtx_row_out[2]));
endmodule
bind iors_io_core iors_io_core_properties u_iors_io_core_properties
(
   .clock(clock), .rst_n(rst_n), .scan_start(scan_start),
   .end_done(end_done), .in_image(in_image), .out_pins(out_pins),
   .ref_req(ref_req), .ref_is_out(ref_is_out), .ref_start(ref_start),
   .ref_count(ref_count), .ref_error(ref_error),
   .matrix_scan_op(matrix_scan_op), .mtx_rows(mtx_rows),
   .mtx_row_out(mtx_row_out), .mtx_result(mtx_result),
   .mtx_error(mtx_error)
);
`default_nettype wire

// *** test/iors_io_core_tb_top.sv ***
/*
  Self-checking bench of the I/O core with a switch matrix model.
  Assumes a short row interval so the matrix scan fits a short run.
*/
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Bench
module iors_io_core_tb_top;
   import iors_pkg::*;
   localparam int ROWS = 10;
   logic clock = 0, rst_n = 0, scan_start = 0, end_done = 0, img_we = 0;
   logic img_value = 0, ref_req = 0, ref_is_out = 0, mop = 0, ref_error;
   logic mtx_error, err;
   logic [1:0] col_group = 2'h3;
   logic [3:0] img_index = 4'h0, mtx_rows = 4'h3;
   logic [4:0] ref_start = 5'h00, ref_count = 5'h08;
   logic [7:0] keys, row_out;
   logic [15:0] out_pins, out_image;
   logic [23:0] pins_lo = 24'h000000;
   logic [31:0] in_image;
   logic [63:0] result;
   int failures = 0, check_count = 0, cycles = 0;
   always #25 clock = ~clock;
   iors_keys u_iors_keys (.rows(row_out), .cols(keys));
   iors_io_core #(.ROW_CYCLES(ROWS)) u_iors_io_core
   (
      .clock(clock), .rst_n(rst_n), .in_pins({keys, pins_lo}),
      .out_pins(out_pins), .scan_start(scan_start), .end_done(end_done),
      .in_image(in_image), .img_we(img_we), .img_index(img_index),
      .img_value(img_value), .out_image(out_image), .ref_req(ref_req),
      .ref_is_out(ref_is_out), .ref_start(ref_start),
      .ref_count(ref_count), .ref_error(ref_error),
      .matrix_scan_op(mop), .mtx_rows(mtx_rows),
      .mtx_col_group(col_group), .mtx_row_out(row_out),
      .mtx_result(result), .mtx_error(mtx_error)
   );
   task automatic tick(int n = 1);
      repeat (n) @(posedge clock);
      #2;
   endtask
   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic refresh(logic o, logic [4:0] s, logic [4:0] c);
      ref_is_out = o;
      ref_start = s;
      ref_count = c;
      ref_req = 1;
      tick();
      ref_req = 0;
      err = ref_error;
      tick();
   endtask
   task automatic wr(logic [3:0] i);
      img_index = i;
      img_value = 1;
      img_we = 1;
      tick();
      img_we = 0;
      tick();
   endtask
   task automatic t_image;
      pins_lo = 24'h00A5C3;
      tick(3);
      chk("image idle", 0, in_image);
      scan_start = 1;
      tick();
      scan_start = 0;
      tick();
      chk("image", 24'h00A5C3, in_image[23:0]);
      wr(4'h3);
      chk("pins early", 0, out_pins);
      end_done = 1;
      tick();
      end_done = 0;
      tick();
      chk("pins", 16'h0008, out_pins);
   endtask
   task automatic t_refresh;
      logic [4:0] bad [5] = '{5'h00, 5'h07, 5'h09, 5'h11, 5'h1F};
      pins_lo = 24'h003C96;
      tick(3);
      refresh(0, 5'h08, 5'h08);
      chk("ref byte", 16'h3CC3, in_image[15:0]);
      refresh(0, 5'h00, 5'h10);
      chk("ref word", 16'h3C96, in_image[15:0]);
      wr(4'h9);
      wr(4'h1);
      chk("out image", 16'h020A, out_image);
      refresh(1, 5'h00, 5'h08);
      chk("ref out", 16'h000A, out_pins);
      pins_lo = 24'h000000;
      tick(3);
      foreach (bad[k])
      begin
         refresh(0, 5'h00, bad[k]);
         chk("count error", 1, err);
      end
      refresh(0, 5'h04, 5'h08);
      chk("start error", 1, err);
      refresh(0, 5'h08, 5'h10);
      chk("span error", 1, err);
      chk("image kept", 16'h3C96, in_image[15:0]);
   endtask
   task automatic t_matrix;
      mop = 1;
      tick(4 * ROWS + 8);
      // Three rows at the column byte from point 24 up.
      chk("rows", 24'h332211, result[23:0]);
      chk("row on", 8'h02, row_out);
      chk("no error", 0, mtx_error);
      mop = 0;
      tick(2);
      chk("rows off", 0, row_out);
      tick(2 * ROWS);
      chk("held", 64'h332211, result);
      mtx_rows = 4'h9;
      mop = 1;
      tick(2);
      chk("row error", 1, mtx_error);
      mop = 0;
      mtx_rows = 4'h3;
      col_group = 2'h1;
      tick();
      mop = 1;
      tick(2);
      chk("col error", 1, mtx_error);
      mop = 0;
      col_group = 2'h3;
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // The ceiling is about 25 times the expected run, to cut a stuck wait.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         report_and_stop();
      end
   end
   initial
   begin
      tick(4);
      rst_n = 1;
      tick();
      t_image();
      t_refresh();
      t_matrix();
      report_and_stop();
   end
endmodule
`default_nettype wire
